// ---- gst_timer.sv ----
// gated sixteen-bit timer with prescaler, gate and register port
// Operation
// RL1: external source counts pin rising edges, else internal
// RL2: gate acts only with gate enable set
// RL3: gate source bit picks pin or comparator
// RL4: low count byte is its own register
// RL5: high count byte is its own register
// RL6: prescale 1/2/4/8, cleared by count write
// RL7: bypass bit counts external edges unsynchronised; code counts the two-flop synchronised pin, without the instruction tick
// RL8: FFFF rolls to 0000, sets overflow flag
// RL9: invert bit inverts gate of either source
// RL10: run gated by active gate; run clear stops
`timescale 1ns/1ns
module gst_timer (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // register port
  input  wire gst_pkg::gst_req_t req,
  output logic      [7:0]       rdata,
  // pins and comparator
  input  wire logic             extCountClockPin,
  input  wire logic             gateInputPin,
  input  wire logic             comparatorTwoOutput,
  // status out
  output logic                  lowPowerOscEnable,
  output logic                  overflowFlag
);

  // ----------------------------------------
  // registers and synchronised inputs
  // ----------------------------------------
  gst_pkg::gst_ctl_t                 ctl_r;
  logic                              gateSrcSel_r;
  logic [15:0]                       count_r;
  logic                              ovf_r;
  logic [gst_pkg::INSTR_W-1:0]       instrCnt_r;
  logic [gst_pkg::PRESC_W-1:0]       presc_r;
  logic                              pinPrev_r;
  logic                              armed_r;
  logic                              pending_r;
  logic [2:0]                        pinsSync;
  logic                              extPin;
  logic                              gateSrc;
  logic                              gateActive;
  logic                              countEnable;
  logic                              instrTick;
  logic                              rise;
  logic                              srcTick;
  logic                              prescTick;
  logic                              inc;
  logic                              wrLo;
  logic                              wrHi;
  logic [gst_pkg::PRESC_W-1:0]       prescLast;

  gst_sync #(
    .WIDTH (3)
  ) pinSync (
    .clock  (clock),
    .rst_n  (rst_n),
    .async  ({extCountClockPin, gateInputPin, comparatorTwoOutput}),
    .synced (pinsSync)
  );

  assign extPin = pinsSync[2];
  assign wrLo   = req.wr && (req.addr == gst_pkg::ADDR_COUNT_LO);
  assign wrHi   = req.wr && (req.addr == gst_pkg::ADDR_COUNT_HI);

  // ----------------------------------------
  // gate
  // ----------------------------------------
  assign gateSrc     = gateSrcSel_r ? pinsSync[0] : pinsSync[1]; // RL3
  assign gateActive  = ctl_r.gateInvert ? gateSrc : !gateSrc; // RL9
  assign countEnable = ctl_r.timerRun && (!ctl_r.gateEnableCtl || gateActive); // RL2 RL10

  // ----------------------------------------
  // clock source
  // ----------------------------------------
  assign instrTick = (instrCnt_r == gst_pkg::INSTR_W'(gst_pkg::INSTR_DIV - 1));
  assign rise      = extPin && !pinPrev_r && armed_r;

  always_comb
  begin
    if (!ctl_r.clockSourceSelect)
      srcTick = instrTick; // RL1
    else if (ctl_r.extSyncBypass)
      srcTick = rise; // RL7
    else
      srcTick = instrTick && (pending_r || rise); // RL1
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      instrCnt_r <= '0;
    else
      instrCnt_r <= instrCnt_r + 1'b1;
  end

  // pin must be seen low after run or a count write before the first counted rise
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinPrev_r <= 1'b0;
      armed_r   <= 1'b0;
      pending_r <= 1'b0;
    end
    else
    begin
      pinPrev_r <= extPin;
      if (wrLo || wrHi || !ctl_r.timerRun)
        armed_r <= 1'b0;
      else if (!extPin)
        armed_r <= 1'b1;
      if (instrTick || !ctl_r.clockSourceSelect || ctl_r.extSyncBypass)
        pending_r <= 1'b0;
      else if (rise)
        pending_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // prescaler
  // ----------------------------------------
  assign prescLast = gst_pkg::PRESC_W'((1 << ctl_r.prescaleSelect) - 1);
  assign prescTick = srcTick && countEnable && (presc_r == prescLast);
  assign inc       = prescTick;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      presc_r <= '0;
    else if (wrLo || wrHi)
      presc_r <= '0; // RL6
    else if (prescTick)
      presc_r <= '0;
    else if (srcTick && countEnable)
      presc_r <= presc_r + 1'b1; // RL6
  end

  // ----------------------------------------
  // counter and overflow
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      count_r <= gst_pkg::COUNT_RST;
    else if (wrLo)
      count_r[7:0] <= req.wdata; // RL4
    else if (wrHi)
      count_r[15:8] <= req.wdata; // RL5
    else if (inc)
      count_r <= count_r + gst_pkg::COUNT_ONE; // RL8
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      ovf_r <= 1'b0;
    else if (inc && (count_r == gst_pkg::COUNT_MAX) && !wrLo && !wrHi)
      ovf_r <= 1'b1; // RL8
    else if (req.wr && (req.addr == gst_pkg::ADDR_FLAGS) && !req.wdata[gst_pkg::OVF_FLAG_BIT])
      ovf_r <= 1'b0;
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl_r        <= gst_pkg::CONTROL_RST;
      gateSrcSel_r <= 1'b0;
    end
    else if (req.wr && (req.addr == gst_pkg::ADDR_CONTROL))
      ctl_r <= req.wdata;
    else if (req.wr && (req.addr == gst_pkg::ADDR_COMP_CTL))
      gateSrcSel_r <= req.wdata[gst_pkg::GATE_SRC_BIT]; // RL3
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= gst_pkg::BYTE_ZERO;
    else if (!req.rd)
      rdata <= gst_pkg::BYTE_ZERO;
    else
    begin
      case (req.addr)
        gst_pkg::ADDR_CONTROL:  rdata <= ctl_r;
        gst_pkg::ADDR_COUNT_LO: rdata <= count_r[7:0]; // RL4
        gst_pkg::ADDR_COUNT_HI: rdata <= count_r[15:8]; // RL5
        gst_pkg::ADDR_COMP_CTL: rdata <= 8'(gateSrcSel_r) << gst_pkg::GATE_SRC_BIT;
        gst_pkg::ADDR_FLAGS:    rdata <= 8'(ovf_r) << gst_pkg::OVF_FLAG_BIT;
        default:                rdata <= gst_pkg::BYTE_ZERO;
      endcase
    end
  end

  assign lowPowerOscEnable = ctl_r.lowPowerOscEnable;
  assign overflowFlag      = ovf_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  rollover_flag_a: assert property (@(posedge clock) disable iff (!rst_n) // RL8
    (inc && count_r == gst_pkg::COUNT_MAX && !wrLo && !wrHi)
      |=> (count_r == gst_pkg::COUNT_RST) && ovf_r)
    else $error("rollover did not clear count or set flag");

  stop_holds_a: assert property (@(posedge clock) disable iff (!rst_n) // RL10
    (!ctl_r.timerRun && !wrLo && !wrHi) |=> $stable(count_r))
    else $error("count moved while stopped");

  gate_blocks_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    (ctl_r.gateEnableCtl && !gateActive) |-> !inc)
    else $error("count advanced with gate inactive");

  gate_ignored_a: assert property (@(posedge clock) disable iff (!rst_n) // RL2
    (ctl_r.timerRun && !ctl_r.gateEnableCtl) |-> countEnable)
    else $error("gate affected count while disabled");

  gate_invert_a: assert property (@(posedge clock) disable iff (!rst_n) // RL9
    gateActive == (gateSrc ~^ ctl_r.gateInvert))
    else $error("gate polarity wrong");

  gate_source_a: assert property (@(posedge clock) disable iff (!rst_n) // RL3
    gateSrcSel_r |-> (gateSrc == pinsSync[0]))
    else $error("comparator not used as gate");

  presc_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    (wrLo || wrHi) |=> (presc_r == '0))
    else $error("prescaler not cleared by count write");

  presc_ratio_a: assert property (@(posedge clock) disable iff (!rst_n) // RL6
    inc |-> (presc_r == prescLast))
    else $error("prescale ratio wrong");

  internal_src_a: assert property (@(posedge clock) disable iff (!rst_n) // RL1
    (!ctl_r.clockSourceSelect && inc) |-> instrTick)
    else $error("internal count off the instruction tick");

  low_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RL4
    (req.rd && req.addr == gst_pkg::ADDR_COUNT_LO) |=> (rdata == $past(count_r[7:0])))
    else $error("low byte read wrong");

  high_read_a: assert property (@(posedge clock) disable iff (!rst_n) // RL5
    (req.rd && req.addr == gst_pkg::ADDR_COUNT_HI) |=> (rdata == $past(count_r[15:8])))
    else $error("high byte read wrong");

  async_edge_a: assert property (@(posedge clock) disable iff (!rst_n) // RL7
    (ctl_r.clockSourceSelect && ctl_r.extSyncBypass && inc) |-> rise)
    else $error("bypass count without pin edge");

endmodule

// ---- gst_pkg.sv ----
// constants and types shared by the gated sixteen-bit timer
package gst_pkg;

  // ----------------------------------------
  // register bus
  // ----------------------------------------
  localparam int            ADDR_W         = 3;
  localparam logic [2:0]    ADDR_CONTROL   = 3'h0;
  localparam logic [2:0]    ADDR_COUNT_LO  = 3'h1;
  localparam logic [2:0]    ADDR_COUNT_HI  = 3'h2;
  localparam logic [2:0]    ADDR_COMP_CTL  = 3'h3;
  localparam logic [2:0]    ADDR_FLAGS     = 3'h4;

  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int            GATE_SRC_BIT   = 1;
  localparam int            OVF_FLAG_BIT   = 0;
  localparam logic [7:0]    CONTROL_RST    = 8'h00;
  localparam logic [7:0]    BYTE_ZERO      = 8'h00;
  localparam logic [15:0]   COUNT_RST      = 16'h0000;
  localparam logic [15:0]   COUNT_MAX      = 16'hFFFF;
  localparam logic [15:0]   COUNT_ONE      = 16'h0001;

  // ----------------------------------------
  // timing: instruction clock is system clock / 4
  // ----------------------------------------
  localparam int            INSTR_DIV      = 4;
  localparam int            INSTR_W        = 2;
  localparam int            PRESC_W        = 3;

  // timer_control layout, bit 7 down to bit 0
  typedef struct packed {
    logic       gateInvert;
    logic       gateEnableCtl;
    logic [1:0] prescaleSelect;
    logic       lowPowerOscEnable;
    logic       extSyncBypass;
    logic       clockSourceSelect;
    logic       timerRun;
  } gst_ctl_t;

  // one register bus request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } gst_req_t;

endpackage

// ---- gst_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module gst_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst_n,
  // data
  input  wire logic [WIDTH-1:0] async,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] stage1_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1_r <= '0;
      synced   <= '0;
    end
    else
    begin
      stage1_r <= async;
      synced   <= stage1_r;
    end
  end

endmodule

// ---- gst_partner.sv ----
// far-side model: count clock, gate pin and comparator output
`timescale 1ns/1ns
module gst_partner (
  // clock
  input  wire logic clock,
  // pins
  output logic      extCountClockPin,
  output logic      gateInputPin,
  output logic      comparatorTwoOutput
);
  initial
  begin
    extCountClockPin = 1'b0;
    gateInputPin = 1'b1;
    comparatorTwoOutput = 1'b0;
  end
  // gate pin and comparator levels, changed just after an edge
  task automatic set_gate(input logic pin, input logic cmp);
    @(posedge clock);
    gateInputPin <= pin;
    comparatorTwoOutput <= cmp;
  endtask
  // count clock idles low between bursts
  task automatic pulses(input int n, input int half);
    repeat (n)
    begin
      repeat (half) @(posedge clock);
      extCountClockPin <= 1'b1;
      repeat (half) @(posedge clock);
      extCountClockPin <= 1'b0;
    end
  endtask
endmodule

// ---- tb_top.sv ----
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ns
module tb_top;
  logic              clock;
  logic              rst_n;
  gst_pkg::gst_req_t req;
  logic [7:0]        rdata;
  logic              extCountClockPin;
  logic              gateInputPin;
  logic              comparatorTwoOutput;
  logic              lowPowerOscEnable;
  logic              overflowFlag;
  int                errCount;
  int                checksDone;
  logic [7:0]        ctlTab[13] = '{8'h07, 8'h17, 8'h27, 8'h37, 8'h03, 8'h47, 8'h47,
                                    8'hC7, 8'hC7, 8'h06, 8'h47, 8'h47, 8'hC7};
  logic [7:0]        cmpTab[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02,
                                    8'h02, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02};
  // gate pin level in bit 1, comparator level in bit 0
  logic [1:0]        gateTab[13] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
                                     2'h2, 2'h2, 2'h2, 2'h1, 2'h1, 2'h1};
  logic [7:0]        expTab[13] = '{8'h08, 8'h04, 8'h02, 8'h01, 8'h08, 8'h00, 8'h08,
                                    8'h00, 8'h08, 8'h00, 8'h08, 8'h00, 8'h08};

  gst_timer i_gst_timer (
    .clock               (clock),
    .rst_n               (rst_n),
    .req                 (req),
    .rdata               (rdata),
    .extCountClockPin    (extCountClockPin),
    .gateInputPin        (gateInputPin),
    .comparatorTwoOutput (comparatorTwoOutput),
    .lowPowerOscEnable   (lowPowerOscEnable),
    .overflowFlag        (overflowFlag)
  );
  gst_partner i_gst_partner (
    .clock               (clock),
    .extCountClockPin    (extCountClockPin),
    .gateInputPin        (gateInputPin),
    .comparatorTwoOutput (comparatorTwoOutput)
  );

  initial
  begin
    clock = 1'b0;
    rst_n = 1'b0;
    req = '0;
    errCount = 0;
    checksDone = 0;
  end
  always #10 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      errCount++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    req <= '0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    req <= '0;
    #1;
    check(rdata, e);
  endtask
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", checksDone, errCount);
    if (errCount == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // reset values, unmapped address, oscillator enable bit
  task automatic test_reset();
    for (int a = 0; a < 6; a++)
      rd(a[2:0], 8'h00);
    check(overflowFlag, 1'b0);
    wr(gst_pkg::ADDR_CONTROL, 8'h08);
    #1;
    check(lowPowerOscEnable, 1'b1);
    rd(gst_pkg::ADDR_CONTROL, 8'h08);
    wr(gst_pkg::ADDR_CONTROL, 8'h00);
  endtask
  // rollover from FFFE on the internal clock
  task automatic test_rollover();
    wr(gst_pkg::ADDR_COUNT_HI, 8'hFF);
    wr(gst_pkg::ADDR_COUNT_LO, 8'hFE);
    rd(gst_pkg::ADDR_COUNT_HI, 8'hFF);
    rd(gst_pkg::ADDR_COUNT_LO, 8'hFE);
    wr(gst_pkg::ADDR_CONTROL, 8'h01);
    repeat (30) @(posedge clock);
    wr(gst_pkg::ADDR_CONTROL, 8'h00);
    rd(gst_pkg::ADDR_COUNT_HI, 8'h00);
    check(overflowFlag, 1'b1);
    rd(gst_pkg::ADDR_FLAGS, 8'h01);
    wr(gst_pkg::ADDR_FLAGS, 8'h01);
    rd(gst_pkg::ADDR_FLAGS, 8'h01);
    wr(gst_pkg::ADDR_FLAGS, 8'h00);
    #1;
    check(overflowFlag, 1'b0);
  endtask
  // prescale, sync modes, gate source, invert, enable and run
  task automatic test_modes();
    for (int i = 0; i < 13; i++)
    begin
      wr(gst_pkg::ADDR_CONTROL, 8'h00);
      i_gst_partner.set_gate(gateTab[i][1], gateTab[i][0]);
      wr(gst_pkg::ADDR_COUNT_HI, 8'h00);
      wr(gst_pkg::ADDR_COUNT_LO, 8'h00);
      wr(gst_pkg::ADDR_COMP_CTL, cmpTab[i]);
      wr(gst_pkg::ADDR_CONTROL, ctlTab[i]);
      i_gst_partner.pulses(8, 8);
      repeat (10) @(posedge clock);
      rd(gst_pkg::ADDR_COUNT_LO, expTab[i]);
    end
  endtask

  initial
  begin
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    test_reset();
    test_rollover();
    test_modes();
    endSim();
  end
  initial
  begin
    #400000;
    errCount++;
    endSim();
  end
endmodule
